// ===== verilog/sbt_pkg.sv
// Shared constants and types for the scan bus transceiver.
package sbt_pkg;

   localparam int HALF_W = 9;
   localparam int BUS_W = 18;
   localparam int NUM_HALVES = 2;
   localparam int PIN_W = 51;
   localparam int IR_W = 8;
   localparam int BSR_W = 48;
   localparam int BCR_W = 3;
   localparam int ID_W = 32;
   localparam int SNAP_W = 36;

   ////////////////////////////////////////////////////////////////////////
   // Positions in the synchronised pin vector
   localparam int PIN_A_LSB = 0;
   localparam int PIN_B_LSB = 18;
   localparam int PIN_LE_AB_LSB = 36;
   localparam int PIN_LE_BA_LSB = 38;
   localparam int PIN_CK_AB_LSB = 40;
   localparam int PIN_CK_BA_LSB = 42;
   localparam int PIN_OE_AB_LSB = 44;
   localparam int PIN_OE_BA_LSB = 46;
   localparam int PIN_TCK = 48;
   localparam int PIN_TMS = 49;
   localparam int PIN_TDI = 50;
   // Output enables, TMS and TDI default high as if pulled up
   localparam logic [50:0] PIN_RST = 51'h6f00000000000;

   ////////////////////////////////////////////////////////////////////////
   // Boundary cell positions
   localparam int BSR_A_LSB = 0;
   localparam int BSR_B_LSB = 18;
   localparam int BSR_CTL_LSB = 36;
   localparam int BSR_OE_AB_LSB = 44;
   localparam int BSR_OE_BA_LSB = 46;
   localparam logic [47:0] BSR_RST = 48'hf00000000000;

   ////////////////////////////////////////////////////////////////////////
   // Instructions
   localparam logic [7:0] IR_RST = 8'h81;
   localparam logic [7:0] IR_CAPTURE = 8'h81;
   localparam logic [7:0] IR_EXTEST = 8'h00;
   localparam logic [7:0] IR_SAMPLE = 8'h82;
   localparam logic [7:0] IR_IDCODE = 8'h81;
   localparam logic [7:0] IR_RUNT = 8'h87;
   localparam logic [7:0] IR_SEL_BCR = 8'h8e;
   localparam logic [7:0] IR_BYPASS = 8'hff;

   // Boundary-control operations
   localparam logic [2:0] BCR_RST = 3'h2;
   localparam logic [2:0] OP_PSA = 3'h2;
   localparam logic [2:0] OP_OUTPUT_PSEUDO_RANDOM_PATTERNS = 3'h3;
   localparam logic [2:0] OP_TOGGLE = 3'h4;

   // Pattern register feedback tap
   localparam int LFSR_TAP = 10;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
      ST_PAUSE_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
      ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
   } sbt_tap_state_t;

   typedef enum logic [1:0] {
      SEL_BYPASS, SEL_ID, SEL_BSR, SEL_BCR
   } sbt_dr_sel_t;

endpackage

// ===== verilog/sbt_dir.sv
// One direction of one 9-bit half: transparent, latched or stored.
`timescale 1ns/1ps
`default_nettype none
module sbt_dir
   import sbt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [HALF_W-1:0] din,
   input wire logic latch_en,
   input wire logic store_clk,
   output logic [HALF_W-1:0] dout
);

   logic store_clk_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         store_clk_q <= 1'b0;
      end else if (clk_en) begin
         store_clk_q <= store_clk;
      end
   end

   // Content is meaningless until the first load or transparent phase
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= '0;
      end else if (clk_en) begin
         if (latch_en) begin
            dout <= din;
         end else if (store_clk && !store_clk_q) begin
            dout <= din;
         end
      end
   end
   // Otherwise held

endmodule
`default_nettype wire

// ===== verilog/sbt_buf2.sv
// Two-entry buffer with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sbt_buf2 #(
   parameter int W = 36
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   logic [W-1:0] slot_q [2];
   logic [1:0] count_q;
   logic rd_ptr_q;
   logic wr_ptr_q;
   logic push;
   logic pop;

   assign in_ready = (count_q != 2'd2);
   assign out_valid = (count_q != 2'd0);
   assign out_data = slot_q[rd_ptr_q];
   assign push = clk_en && in_valid && in_ready;
   assign pop = clk_en && out_valid && out_ready;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_q[0] <= '0;
         slot_q[1] <= '0;
      end else if (push) begin
         slot_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 2'd0;
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push && !pop) begin
            count_q <= count_q + 2'd1;
         end else if (pop && !push) begin
            count_q <= count_q - 2'd1;
         end
      end
   end

endmodule
`default_nettype wire

// ===== verilog/sbt_top.sv
// Scan bus transceiver: two 9-bit halves, test port and boundary cells.
//
// Summary of operation
// - Latch enable high passes A to B.
// - Latch enable low, clock steady: hold output.
// - Latch enable low: store on clock rise.
// - Output enable low drives B side.
// - Output enable high floats B side.
// - B to A mirrors A to B.
// - Each 9-bit half has own controls.
// - Test mode hands boundary to test logic.
// - Test port in normal mode leaves data.
// - Sample on TCK rise, change on fall.
// - Shift TDI into IR or data register.
// - Selected register's serial output on TDO.
// - TMS steers the test state machine.
// - Unconnected TMS and TDI read high.
// - Unconnected output enable reads high.
// - Signature compression and pseudo-random patterns.
// - Pin snapshots and boundary output toggling.
// - Powers up in test-logic reset.
// - TMS high five cycles reaches reset.
`timescale 1ns/1ps
`default_nettype none
module sbt_top
   import sbt_pkg::*;
#(
   // Arbitrary neutral identification value
   parameter logic [31:0] ID_CODE = 32'h0a5a5001
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [BUS_W-1:0] a_in,
   output logic [BUS_W-1:0] a_out,
   output logic [BUS_W-1:0] a_oe,
   input wire logic [BUS_W-1:0] b_in,
   output logic [BUS_W-1:0] b_out,
   output logic [BUS_W-1:0] b_oe,
   input wire logic [1:0] a_to_b_output_enable_n,
   input wire logic [1:0] b_to_a_output_enable_n,
   input wire logic [1:0] a_to_b_latch_enable,
   input wire logic [1:0] b_to_a_latch_enable,
   input wire logic [1:0] a_to_b_store_clock,
   input wire logic [1:0] b_to_a_store_clock,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   output logic snap_valid,
   input wire logic snap_ready,
   output logic [SNAP_W-1:0] snap_data
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_m_q;
   logic [PIN_W-1:0] pin_s_q;
   logic tck_q;

   assign pin_raw = {tdi, tms, tck, b_to_a_output_enable_n,
      a_to_b_output_enable_n, b_to_a_store_clock, a_to_b_store_clock,
      b_to_a_latch_enable, a_to_b_latch_enable, b_in, a_in};

   // Pullup levels stand in until real pin values arrive
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_m_q <= PIN_RST;
         pin_s_q <= PIN_RST;
         tck_q <= 1'b0;
      end else if (clk_en) begin
         pin_m_q <= pin_raw;
         pin_s_q <= pin_m_q;
         tck_q <= pin_s_q[PIN_TCK];
      end
   end

   logic [BUS_W-1:0] a_s;
   logic [BUS_W-1:0] b_s;
   logic tms_s;
   logic tdi_s;
   logic tck_rise;
   logic tck_fall;

   assign a_s = pin_s_q[PIN_A_LSB +: BUS_W];
   assign b_s = pin_s_q[PIN_B_LSB +: BUS_W];
   assign tms_s = pin_s_q[PIN_TMS];
   assign tdi_s = pin_s_q[PIN_TDI];
   assign tck_rise = clk_en && pin_s_q[PIN_TCK] && !tck_q;
   assign tck_fall = clk_en && !pin_s_q[PIN_TCK] && tck_q;

   ////////////////////////////////////////////////////////////////////////
   // Normal datapath, frozen while test mode owns the pins
   logic test_mode;
   logic dp_en;
   logic [BUS_W-1:0] ab_data;
   logic [BUS_W-1:0] ba_data;

   assign dp_en = clk_en && !test_mode;

   for (genvar h = 0; h < NUM_HALVES; h++) begin : g_half
      sbt_dir u_ab (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .clk_en(dp_en),
         .din(a_s[h*HALF_W +: HALF_W]),
         .latch_en(pin_s_q[PIN_LE_AB_LSB + h]),
         .store_clk(pin_s_q[PIN_CK_AB_LSB + h]),
         .dout(ab_data[h*HALF_W +: HALF_W])
      );
      sbt_dir u_ba (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .clk_en(dp_en),
         .din(b_s[h*HALF_W +: HALF_W]),
         .latch_en(pin_s_q[PIN_LE_BA_LSB + h]),
         .store_clk(pin_s_q[PIN_CK_BA_LSB + h]),
         .dout(ba_data[h*HALF_W +: HALF_W])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Test state machine
   sbt_tap_state_t state_q;
   sbt_tap_state_t state_d;
   logic snap_stall;
   logic tap_step;

   // A pending snapshot that cannot leave drops any TCK rising edge; falling edges still act
   assign tap_step = tck_rise && !snap_stall;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RESET: state_d = tms_s ? ST_RESET : ST_IDLE;
         ST_IDLE: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: state_d = tms_s ? ST_EX2_DR : ST_PAUSE_DR;
         ST_EX2_DR: state_d = tms_s ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: state_d = tms_s ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: state_d = tms_s ? ST_EX2_IR : ST_PAUSE_IR;
         ST_EX2_IR: state_d = tms_s ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_RESET;
      end else if (tap_step) begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction register
   logic [IR_W-1:0] ir_sh_q;
   logic [IR_W-1:0] ir_q;
   sbt_dr_sel_t dr_sel;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_sh_q <= IR_RST;
      end else if (tap_step) begin
         if (state_q == ST_CAP_IR) begin
            ir_sh_q <= IR_CAPTURE;
         end else if (state_q == ST_SH_IR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
         end
      end
   end

   // Update lands on the falling edge after entry to the update state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_q <= IR_RST;
      end else if (tck_fall) begin
         if (state_q == ST_RESET) begin
            ir_q <= IR_RST;
         end else if (state_q == ST_UPD_IR) begin
            ir_q <= ir_sh_q;
         end
      end
   end

   always_comb begin
      unique case (ir_q)
         IR_EXTEST, IR_SAMPLE: dr_sel = SEL_BSR;
         IR_IDCODE: dr_sel = SEL_ID;
         IR_SEL_BCR: dr_sel = SEL_BCR;
         default: dr_sel = SEL_BYPASS;
      endcase
   end

   assign test_mode = (ir_q == IR_EXTEST) || (ir_q == IR_RUNT);

   ////////////////////////////////////////////////////////////////////////
   // Data registers
   logic [BSR_W-1:0] bsr_q;
   logic [BSR_W-1:0] upd_q;
   logic [BCR_W-1:0] bcr_sh_q;
   logic [BCR_W-1:0] bcr_q;
   logic [ID_W-1:0] id_q;
   logic byp_q;
   logic run_op;
   logic [BUS_W-1:0] psa_next;
   logic [BUS_W-1:0] output_pseudo_random_patterns_next;
   logic [BUS_W-1:0] output_pseudo_random_patterns_cur;

   assign run_op = tap_step && (state_q == ST_IDLE) && (ir_q == IR_RUNT);
   assign output_pseudo_random_patterns_cur = upd_q[BSR_B_LSB +: BUS_W];
   assign psa_next = {bsr_q[BUS_W-2:0],
      bsr_q[BUS_W-1] ^ bsr_q[LFSR_TAP]} ^ a_s;
   assign output_pseudo_random_patterns_next = {output_pseudo_random_patterns_cur[BUS_W-2:0],
      output_pseudo_random_patterns_cur[BUS_W-1] ^ output_pseudo_random_patterns_cur[LFSR_TAP]};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bsr_q <= BSR_RST;
      end else if (tap_step) begin
         if (state_q == ST_CAP_DR && dr_sel == SEL_BSR) begin
            bsr_q <= pin_s_q[BSR_W-1:0];
         end else if (state_q == ST_SH_DR && dr_sel == SEL_BSR) begin
            bsr_q <= {tdi_s, bsr_q[BSR_W-1:1]};
         end else if (run_op && bcr_q == OP_PSA) begin
            bsr_q[BSR_A_LSB +: BUS_W] <= psa_next;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         upd_q <= BSR_RST;
      end else if (clk_en && state_q == ST_RESET) begin
         upd_q[BSR_W-1:BSR_OE_AB_LSB] <= BSR_RST[BSR_W-1:BSR_OE_AB_LSB];
      end else if (tck_fall && state_q == ST_UPD_DR && dr_sel == SEL_BSR) begin
         upd_q <= bsr_q;
      end else if (run_op && bcr_q == OP_OUTPUT_PSEUDO_RANDOM_PATTERNS) begin
         upd_q[BSR_B_LSB +: BUS_W] <= output_pseudo_random_patterns_next;
      end else if (run_op && bcr_q == OP_TOGGLE) begin
         upd_q[SNAP_W-1:0] <= ~upd_q[SNAP_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bcr_sh_q <= BCR_RST;
         id_q <= '0;
         byp_q <= 1'b0;
      end else if (tap_step) begin
         if (state_q == ST_CAP_DR) begin
            bcr_sh_q <= bcr_q;
            id_q <= ID_CODE;
            byp_q <= 1'b0;
         end else if (state_q == ST_SH_DR) begin
            if (dr_sel == SEL_BCR) begin
               bcr_sh_q <= {tdi_s, bcr_sh_q[BCR_W-1:1]};
            end
            if (dr_sel == SEL_ID) begin
               id_q <= {tdi_s, id_q[ID_W-1:1]};
            end
            byp_q <= tdi_s;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bcr_q <= BCR_RST;
      end else if (tck_fall) begin
         if (state_q == ST_RESET) begin
            bcr_q <= BCR_RST;
         end else if (state_q == ST_UPD_DR && dr_sel == SEL_BCR) begin
            bcr_q <= bcr_sh_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial output, changes on the falling edge only
   logic dr_lsb;

   always_comb begin
      unique case (dr_sel)
         SEL_BSR: dr_lsb = bsr_q[0];
         SEL_ID: dr_lsb = id_q[0];
         SEL_BCR: dr_lsb = bcr_sh_q[0];
         SEL_BYPASS: dr_lsb = byp_q;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo <= (state_q == ST_SH_IR) ? ir_sh_q[0] : dr_lsb;
         tdo_oe <= (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Snapshot stream of captured pin levels
   logic snap_pend_q;
   logic [SNAP_W-1:0] snap_word_q;
   logic buf_in_ready;

   assign snap_stall = snap_pend_q && !buf_in_ready;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_pend_q <= 1'b0;
         snap_word_q <= '0;
      end else if (clk_en) begin
         if (tap_step && state_q == ST_CAP_DR && dr_sel == SEL_BSR) begin
            snap_pend_q <= 1'b1;
            snap_word_q <= {b_s, a_s};
         end else if (buf_in_ready) begin
            snap_pend_q <= 1'b0;
         end
      end
   end

   sbt_buf2 #(
      .W(SNAP_W)
   ) u_snap_buf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(snap_pend_q),
      .in_ready(buf_in_ready),
      .in_data(snap_word_q),
      .out_valid(snap_valid),
      .out_ready(snap_ready),
      .out_data(snap_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers
   logic [BUS_W-1:0] a_en_d;
   logic [BUS_W-1:0] b_en_d;
   logic [1:0] oe_ab_n;
   logic [1:0] oe_ba_n;

   // Test mode takes enables from cells, normal mode from pins
   assign oe_ab_n = test_mode ? upd_q[BSR_OE_AB_LSB +: 2]
      : pin_s_q[PIN_OE_AB_LSB +: 2];
   assign oe_ba_n = test_mode ? upd_q[BSR_OE_BA_LSB +: 2]
      : pin_s_q[PIN_OE_BA_LSB +: 2];
   assign b_en_d = {{HALF_W{!oe_ab_n[1]}}, {HALF_W{!oe_ab_n[0]}}};
   assign a_en_d = {{HALF_W{!oe_ba_n[1]}}, {HALF_W{!oe_ba_n[0]}}};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         a_out <= '0;
         b_out <= '0;
         a_oe <= '0;
         b_oe <= '0;
      end else if (clk_en) begin
         b_oe <= b_en_d;
         a_oe <= a_en_d;
         if (test_mode) begin
            a_out <= upd_q[BSR_A_LSB +: BUS_W];
            b_out <= upd_q[BSR_B_LSB +: BUS_W];
         end else begin
            a_out <= ba_data;
            b_out <= ab_data;
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/sbt_bus_model.sv
// Far-side bus logic on the A and B sides of the transceiver.
`timescale 1ns/1ps
`default_nettype none
module sbt_bus_model
   import sbt_pkg::*;
(
   input wire logic [BUS_W-1:0] a_far,
   input wire logic [BUS_W-1:0] b_far,
   input wire logic [BUS_W-1:0] a_out,
   input wire logic [BUS_W-1:0] a_oe,
   input wire logic [BUS_W-1:0] b_out,
   input wire logic [BUS_W-1:0] b_oe,
   output logic [BUS_W-1:0] a_pin,
   output logic [BUS_W-1:0] b_pin
);
   // Far side backs off on every bit the device drives, so no contention
   always_comb begin
      a_pin = (a_oe & a_out) | (~a_oe & a_far);
      b_pin = (b_oe & b_out) | (~b_oe & b_far);
   end
endmodule
`default_nettype wire

// ===== tb/sbt_top_sva.sv
// Port checks for the scan bus transceiver in normal mode.
`timescale 1ns/1ps
`default_nettype none
module sbt_top_chk
   import sbt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [BUS_W-1:0] a_in,
   input wire logic [BUS_W-1:0] a_out,
   input wire logic [BUS_W-1:0] a_oe,
   input wire logic [BUS_W-1:0] b_in,
   input wire logic [BUS_W-1:0] b_out,
   input wire logic [BUS_W-1:0] b_oe,
   input wire logic [1:0] a_to_b_output_enable_n,
   input wire logic [1:0] b_to_a_output_enable_n,
   input wire logic [1:0] a_to_b_latch_enable,
   input wire logic [1:0] b_to_a_latch_enable,
   input wire logic [1:0] a_to_b_store_clock,
   input wire logic snap_valid,
   input wire logic snap_ready,
   input wire logic [SNAP_W-1:0] snap_data
);
   ////////////////////////////////////////
   // Normal-mode checks; test-mode scenario keeps these pins steady
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_ab_pass: assert property (
      (a_to_b_latch_enable[0] && !a_to_b_output_enable_n[0]) [*7]
      |-> b_out[8:0] == $past(a_in[8:0], 4))
      else $error("b_out not following a_in");
   a_ba_pass: assert property (
      (b_to_a_latch_enable[1] && !b_to_a_output_enable_n[1]) [*7]
      |-> a_out[17:9] == $past(b_in[17:9], 4))
      else $error("a_out not following b_in");
   a_ab_hold: assert property (
      (!a_to_b_latch_enable[0] && $stable(a_to_b_store_clock[0])) [*7]
      |-> $stable(b_out[8:0]))
      else $error("b_out changed while held");
   a_ab_store: assert property (
      (!a_to_b_latch_enable[0] && !a_to_b_output_enable_n[0]) [*4]
      ##0 $rose(a_to_b_store_clock[0])
      |-> ##5 b_out[8:0] == $past(a_in[8:0], 5))
      else $error("b_out missed stored value");
   a_ab_drive: assert property (
      (!a_to_b_output_enable_n[0]) [*4] |-> b_oe[8:0] == 9'h1ff)
      else $error("b side not driven");
   a_ab_float: assert property (
      a_to_b_output_enable_n[0] [*4] |-> b_oe[8:0] == 9'h000)
      else $error("b side not released");
   a_ba_float: assert property (
      b_to_a_output_enable_n[1] [*4] |-> a_oe[17:9] == 9'h000)
      else $error("a side upper half not released");
   a_snap_hold: assert property (
      snap_valid && !snap_ready |=> snap_valid && $stable(snap_data))
      else $error("snapshot dropped while stalled");

   cover property ($rose(a_to_b_store_clock[0]));
   cover property (snap_valid && !snap_ready);
   cover property (snap_valid && snap_ready);
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the scan bus transceiver.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sbt_pkg::*;
   // Arbitrary identification value
   localparam logic [31:0] ID_VAL = 32'h13572469;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic tck = 1'b0;
   logic tms = 1'b1;
   logic tdi = 1'b1;
   logic snap_ready = 1'b0;
   logic tdo, tdo_oe, snap_valid;
   logic [BUS_W-1:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
   logic [BUS_W-1:0] a_far = 18'h00000;
   logic [BUS_W-1:0] b_far = 18'h00000;
   logic [1:0] oe_ab_n = 2'h3;
   logic [1:0] oe_ba_n = 2'h3;
   logic [1:0] le_ab = 2'h0;
   logic [1:0] le_ba = 2'h0;
   logic [1:0] ck_ab = 2'h0;
   logic [1:0] ck_ba = 2'h0;
   logic [SNAP_W-1:0] snap_data;
   int fails = 0;
   int comparisons = 0;
   int cyc = 0;

   sbt_top #(.ID_CODE(ID_VAL)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
      .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
      .b_in(b_in), .b_out(b_out), .b_oe(b_oe),
      .a_to_b_output_enable_n(oe_ab_n), .b_to_a_output_enable_n(oe_ba_n),
      .a_to_b_latch_enable(le_ab), .b_to_a_latch_enable(le_ba),
      .a_to_b_store_clock(ck_ab), .b_to_a_store_clock(ck_ba),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .snap_valid(snap_valid), .snap_ready(snap_ready),
      .snap_data(snap_data));

   sbt_bus_model bus (
      .a_far(a_far), .b_far(b_far), .a_out(a_out), .a_oe(a_oe),
      .b_out(b_out), .b_oe(b_oe), .a_pin(a_in), .b_pin(b_in));

   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [35:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // TCK phases kept at 4+ periods: the port sees them after sync
   task automatic tck_cyc(input logic m, input logic d, output logic o);
      @(posedge ref_clk);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge ref_clk);
      tck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      tck <= 1'b0;
      step(5);
      o = tdo;
   endtask

   task automatic scan(input logic ir, input logic [47:0] din,
      input int n, output logic [47:0] got);
      logic o;
      got = 48'h0;
      tck_cyc(1'b0, 1'b1, o);
      tck_cyc(1'b1, 1'b1, o);
      if (ir)
         tck_cyc(1'b1, 1'b1, o);
      tck_cyc(1'b0, 1'b1, o);
      tck_cyc(1'b0, 1'b1, o);
      got[0] = o;
      chk("tdo_oe shift", 1'b1, tdo_oe);
      for (int i = 0; i < n; i++) begin
         tck_cyc(i == n - 1, din[i], o);
         if (i < n - 1)
            got[i + 1] = o;
      end
      tck_cyc(1'b1, 1'b1, o);
      tck_cyc(1'b0, 1'b1, o);
      chk("tdo_oe idle", 1'b0, tdo_oe);
   endtask

   task automatic snap_once();
      logic o;
      tck_cyc(1'b0, 1'b1, o);
      tck_cyc(1'b1, 1'b1, o);
      tck_cyc(1'b0, 1'b1, o);
      tck_cyc(1'b1, 1'b1, o);
      tck_cyc(1'b1, 1'b1, o);
      tck_cyc(1'b0, 1'b1, o);
   endtask

   task automatic take();
      @(posedge ref_clk);
      snap_ready <= 1'b1;
      @(posedge ref_clk);
      snap_ready <= 1'b0;
      #1;
   endtask

   ////////////////////////////////////////
   task automatic s_pass_store();
      @(posedge ref_clk);
      oe_ab_n[0] <= 1'b0;
      le_ab[0] <= 1'b1;
      a_far[8:0] <= 9'h1a5;
      step(6);
      chk("b_oe", 9'h1ff, b_oe[8:0]);
      chk("b_out pass", 9'h1a5, b_out[8:0]);
      @(posedge ref_clk);
      le_ab[0] <= 1'b0;
      step(4);
      @(posedge ref_clk);
      a_far[8:0] <= 9'h133;
      step(6);
      chk("b_out held", 9'h1a5, b_out[8:0]);
      @(posedge ref_clk);
      ck_ab[0] <= 1'b1;
      step(7);
      chk("b_out stored", 9'h133, b_out[8:0]);
      @(posedge ref_clk);
      ck_ab[0] <= 1'b0;
      a_far[8:0] <= 9'h0cc;
      step(7);
      chk("b_out after fall", 9'h133, b_out[8:0]);
   endtask

   task automatic s_mirror();
      @(posedge ref_clk);
      oe_ba_n[1] <= 1'b0;
      le_ba[1] <= 1'b1;
      b_far[17:9] <= 9'h16c;
      oe_ab_n[0] <= 1'b1;
      step(7);
      chk("a_oe upper", 9'h1ff, a_oe[17:9]);
      chk("a_out upper", 9'h16c, a_out[17:9]);
      chk("a_oe lower", 9'h000, a_oe[8:0]);
      chk("b_oe off", 9'h000, b_oe[8:0]);
   endtask

   task automatic s_tap_snap();
      logic [47:0] got;
      @(posedge ref_clk);
      oe_ab_n[0] <= 1'b0;
      le_ab[0] <= 1'b1;
      a_far[8:0] <= 9'h0f3;
      scan(1'b1, {40'h0, IR_SAMPLE}, 8, got);
      chk("ir capture", IR_CAPTURE, got[7:0]);
      chk("b_out during scan", 9'h0f3, b_out[8:0]);
      @(posedge ref_clk);
      le_ab[0] <= 1'b0;
      oe_ab_n[0] <= 1'b1;
      oe_ba_n[1] <= 1'b1;
      a_far <= 18'h2a5c3;
      b_far <= 18'h15a3c;
      snap_once();
      @(posedge ref_clk);
      a_far <= 18'h0f0f0;
      snap_once();
      step(10);
      chk("snap first", {18'h15a3c, 18'h2a5c3}, snap_data);
      chk("snap_valid", 1'b1, snap_valid);
      take();
      chk("snap second", {18'h15a3c, 18'h0f0f0}, snap_data);
      take();
      step(2);
      chk("snap drained", 1'b0, snap_valid);
   endtask

   task automatic s_tms_reset();
      logic [47:0] got;
      logic o;
      scan(1'b1, {40'h0, IR_BYPASS}, 8, got);
      repeat (5) tck_cyc(1'b1, 1'b1, o);
      scan(1'b0, 48'h0, 32, got);
      chk("id after reset", ID_VAL, got[31:0]);
   endtask

   task automatic s_extest();
      logic [47:0] got;
      scan(1'b1, {40'h0, IR_SAMPLE}, 8, got);
      // Preload keeps the held low B half, so entry does not glitch it
      scan(1'b0, {4'hd, 8'h00, 9'h15a, 9'h0f3, 18'h00000}, 48, got);
      scan(1'b1, {40'h0, IR_EXTEST}, 8, got);
      step(2);
      chk("extest b_out", {9'h15a, 9'h0f3}, b_out);
      chk("extest b_oe", {9'h1ff, 9'h000}, b_oe);
      chk("extest a_out", 18'h00000, a_out);
      chk("extest a_oe", 18'h00000, a_oe);
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      step(3);
      chk("a_oe reset", 18'h00000, a_oe);
      chk("b_oe reset", 18'h00000, b_oe);
      chk("tdo_oe reset", 1'b0, tdo_oe);
      s_pass_store();
      s_mirror();
      s_tap_snap();
      s_tms_reset();
      s_extest();
      print_verdict();
   end
endmodule

bind sbt_top sbt_top_chk chk_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .a_in(a_in), .a_out(a_out),
   .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe),
   .a_to_b_output_enable_n(a_to_b_output_enable_n),
   .b_to_a_output_enable_n(b_to_a_output_enable_n),
   .a_to_b_latch_enable(a_to_b_latch_enable),
   .b_to_a_latch_enable(b_to_a_latch_enable),
   .a_to_b_store_clock(a_to_b_store_clock),
   .snap_valid(snap_valid), .snap_ready(snap_ready),
   .snap_data(snap_data));
`default_nettype wire
